//--- rtl/bcs_ctrl_top.sv
/*
 Digital core of a sensorless three-phase motor driver: serial control word,
 six-state output sequencer, braking, tachometer and speed reference counting.
 Assumes the analog side delivers comparator levels and capacitor-timed events
 as asynchronous levels, and the host clocks the serial port.
*/
// What this block does
// - Deselected port ignores clock and data.
// - Selected: shift data on serial clock rise.
// - Latch word on select rise; bit 0 last.
// - Bit 0 selects sleep or run.
// - Bit 1: step only on startup oscillator.
// - Bit 2 commands dynamic brake.
// - Bits 3,4 select current limit step.
// - Active-low bits 5-18 sum reference count.
// - Bit 19 selects speed feedback source.
// - Bits 20,21 set pole count.
// - Bits 22,23 route diagnostic output.
// - Reset low clears whole control word.
// - Brake: high sides off, low sides on.
// - Brake stays latched until reset.
// - Internal mode: count toggles, rev_a per revolution.
// - Rev_a rise starts reference pulse.
// - Falling-edge difference drives pump up/down.
// - Sector mode takes rev_a from sector input.
// - Loop init flag until first fast error.
// - Watchdog advances sequencer without good polarity.
// - Six states: one sources, one sinks, one off.
// - Zero-cross toggle flips at each crossing outside blanking, step, sleep, brake.
`timescale 1ns/10ps
`default_nettype none

module bcs_ctrl_top (
  // System clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial port, its own clock domain
  input wire logic serial_clk,
  input wire logic port_sel_n,
  input wire logic serial_din,
  // Asynchronous pins
  input wire logic reset_n,
  input wire logic brake_n,
  input wire logic sector_in,
  input wire logic ref_osc_clock,
  input wire logic bemf_cmp,
  input wire logic st_osc_evt,
  input wire logic cd_done_evt,
  input wire logic blank_end_evt,
  input wire logic wd_timeout_evt,
  input wire logic therm_flag,
  // Power stage and analog controls
  output var bcs_pkg::bcs_drive_type drive,
  output logic [1:0] ilim_code,
  output logic run_mode,
  output logic loop_init_flag,
  output logic pump_up,
  output logic pump_down,
  // Diagnostics
  output logic diag_out
);
  import bcs_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Table codes list the lower word bit first
  function automatic logic [1:0] swap2(input logic [1:0] raw);
    swap2 = {raw[0], raw[1]};
  endfunction

  function automatic logic [5:0] seq_drive(input bcs_seq_type s);
    case (s)
      SEQ_S1: seq_drive = {3'h1, 3'h2};
      SEQ_S2: seq_drive = {3'h4, 3'h2};
      SEQ_S3: seq_drive = {3'h4, 3'h1};
      SEQ_S4: seq_drive = {3'h2, 3'h1};
      SEQ_S5: seq_drive = {3'h2, 3'h4};
      SEQ_S6: seq_drive = {3'h1, 3'h4};
      default: seq_drive = DRIVE_OFF;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Serial shift register (serial clock domain)
  // ------------------------------------------------------------
  logic [CTL_W-1:0] shift_ff;

  // Shifting only happens while selected, inside a frame, so no reset is needed here
  always_ff @(posedge serial_clk) begin
    if (!port_sel_n) begin
      shift_ff <= {shift_ff[CTL_W-2:0], serial_din};
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [PIN_W-1:0] sy_vec;
  bcs_pin_type sy;
  bcs_pin_type sy_q_ff;
  bcs_pin_type rise;
  bcs_pin_type fall;

  bcs_sync #(.W(PIN_W), .INIT(PIN_INIT)) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({reset_n, port_sel_n, brake_n, sector_in, ref_osc_clock, bemf_cmp,
               st_osc_evt, cd_done_evt, blank_end_evt, wd_timeout_evt, therm_flag}),
    .sync_out(sy_vec)
  );

  assign sy = bcs_pin_type'(sy_vec);

  // Previous synchronised value for edges
  always_ff @(posedge clock) begin
    if (rst) begin
      sy_q_ff <= bcs_pin_type'(PIN_INIT);
    end else begin
      sy_q_ff <= sy;
    end
  end

  assign rise = bcs_pin_type'(sy & ~sy_q_ff);
  assign fall = bcs_pin_type'(~sy & sy_q_ff);

  logic dev_rst;
  logic sel_rise;
  assign dev_rst = rst | ~sy.reset_n;
  assign sel_rise = rise.sel_n;

  // ------------------------------------------------------------
  // Control word
  // ------------------------------------------------------------
  bcs_ctl_type ctrl_ff;
  bcs_ctl_type shift_word;
  logic [1:0] pole_code_ff;
  // Read directly; the copy is taken only on select rise, not on every shift
  assign shift_word = bcs_ctl_type'(shift_ff);

  // Shift register is frozen while selection is high, so the copy is safe
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      ctrl_ff <= bcs_ctl_type'(CTL_RESET);
    end else if (sel_rise) begin
      ctrl_ff <= shift_word;
    end
  end

  // Reserved pole code leaves the last valid count in force
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      pole_code_ff <= POLE_8;
    end else if (sel_rise && swap2(shift_word.pole_raw) != POLE_RSVD) begin
      pole_code_ff <= swap2(shift_word.pole_raw);
    end
  end

  assign run_mode = ctrl_ff.run;
  assign ilim_code = swap2(ctrl_ff.ilim_raw);

  // ------------------------------------------------------------
  // Braking
  // ------------------------------------------------------------
  logic brake_latch_ff;

  // Once set only a reset releases it
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      brake_latch_ff <= 1'b0;
    end else if (!sy.brake_n || ctrl_ff.brake) begin
      brake_latch_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Blanking, watchdog and zero crossings
  // ------------------------------------------------------------
  logic comm;
  logic blank_ff;
  logic armed_ff;
  logic zc_valid;
  logic wd_fail;
  logic zero_cross_toggle_ff;
  logic active;

  assign active = ctrl_ff.run & ~brake_latch_ff;
  assign zc_valid = (rise.bemf | fall.bemf) & ~blank_ff & ~ctrl_ff.step & active;
  assign wd_fail = rise.wd_timeout & armed_ff & ~ctrl_ff.step & active;
  // Step mode ignores back-EMF timing entirely
  assign comm = active & (ctrl_ff.step ? rise.st_osc :
                (rise.st_osc | rise.cd_done | wd_fail));

  // Comparators are blind from each commutation to the end of blanking
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      blank_ff <= 1'b0;
    end else if (comm) begin
      blank_ff <= 1'b1;
    end else if (rise.blank_end) begin
      blank_ff <= 1'b0;
    end
  end

  // Watchdog window: armed after blanking until a good crossing
  always_ff @(posedge clock) begin
    if (dev_rst || comm || zc_valid) begin
      armed_ff <= 1'b0;
    end else if (rise.blank_end && blank_ff) begin
      armed_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (dev_rst) begin
      zero_cross_toggle_ff <= 1'b0;
    end else if (zc_valid) begin
      zero_cross_toggle_ff <= ~zero_cross_toggle_ff;
    end
  end

  // ------------------------------------------------------------
  // Output sequencer
  // ------------------------------------------------------------
  bcs_seq_type seq_ff;
  bcs_seq_type nxt_seq;
  bcs_drive_type drive_ff;

  always_comb begin
    case (seq_ff)
      SEQ_S1: nxt_seq = SEQ_S2;
      SEQ_S2: nxt_seq = SEQ_S3;
      SEQ_S3: nxt_seq = SEQ_S4;
      SEQ_S4: nxt_seq = SEQ_S5;
      SEQ_S5: nxt_seq = SEQ_S6;
      default: nxt_seq = SEQ_S1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (dev_rst) begin
      seq_ff <= SEQ_S1;
    end else if (comm) begin
      seq_ff <= nxt_seq;
    end
  end

  // Brake outranks sleep, which outranks the sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      drive_ff <= bcs_drive_type'(DRIVE_OFF);
    end else if (brake_latch_ff) begin
      drive_ff <= bcs_drive_type'(DRIVE_BRAKE);
    end else if (!ctrl_ff.run) begin
      drive_ff <= bcs_drive_type'(DRIVE_OFF);
    end else begin
      drive_ff <= bcs_drive_type'(seq_drive(seq_ff));
    end
  end

  assign drive = drive_ff;

  // ------------------------------------------------------------
  // Tachometer
  // ------------------------------------------------------------
  logic [ZCT_W-1:0] zct_cnt_ff;
  logic [ZCT_W-1:0] zct_lim;
  logic rev_a_int_ff;
  logic rev_a_ff;
  logic rev_a_rise;
  logic rev_a_fall;

  always_comb begin
    case (pole_code_ff)
      POLE_16: zct_lim = ZCT_CYC_16P;
      POLE_12: zct_lim = ZCT_CYC_12P;
      default: zct_lim = ZCT_CYC_8P;
    endcase
  end

  // One full toggle cycle counted per rising toggle
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      zct_cnt_ff <= '0;
      rev_a_int_ff <= 1'b0;
    end else if (zc_valid && !zero_cross_toggle_ff) begin
      if (zct_cnt_ff >= zct_lim - 5'h01) begin
        zct_cnt_ff <= '0;
        rev_a_int_ff <= ~rev_a_int_ff;
      end else begin
        zct_cnt_ff <= zct_cnt_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (dev_rst) begin
      rev_a_ff <= 1'b0;
    end else begin
      rev_a_ff <= ctrl_ff.sector ? sy.sector : rev_a_int_ff;
    end
  end

  logic rev_a_q_ff;
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      rev_a_q_ff <= 1'b0;
    end else begin
      rev_a_q_ff <= rev_a_ff;
    end
  end

  assign rev_a_rise = rev_a_ff & ~rev_a_q_ff;
  assign rev_a_fall = ~rev_a_ff & rev_a_q_ff;

  // ------------------------------------------------------------
  // Speed reference and error
  // ------------------------------------------------------------
  logic [REF_W-1:0] ref_total;
  logic [REF_W-1:0] ref_cnt_ff;
  logic ref_ff;
  logic ref_end;
  logic err_fast;
  logic pump_up_ff;
  logic pump_dn_ff;
  logic loop_init_ff;

  assign ref_total = {~ctrl_ff.ref_n, 4'h0};
  assign ref_end = ref_ff & rise.osc & (ref_cnt_ff == 18'h0_0001);

  // Counts reference oscillator rising edges; a zero total gives no pulse
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      ref_ff <= 1'b0;
      ref_cnt_ff <= '0;
    end else if (rev_a_rise) begin
      ref_ff <= (ref_total != '0);
      ref_cnt_ff <= ref_total;
    end else if (ref_end) begin
      ref_ff <= 1'b0;
      ref_cnt_ff <= '0;
    end else if (ref_ff && rise.osc) begin
      ref_cnt_ff <= ref_cnt_ff - 18'h0_0001;
    end
  end

  // Rev_a ends before the reference: motor is too fast
  assign err_fast = rev_a_fall & ref_ff & ~ref_end;

  always_ff @(posedge clock) begin
    if (dev_rst) begin
      pump_dn_ff <= 1'b0;
    end else if (err_fast) begin
      pump_dn_ff <= 1'b1;
    end else if (ref_end || rev_a_rise) begin
      pump_dn_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (dev_rst) begin
      pump_up_ff <= 1'b0;
    end else if (ref_end && rev_a_ff) begin
      pump_up_ff <= 1'b1;
    end else if (rev_a_fall) begin
      pump_up_ff <= 1'b0;
    end
  end

  // Held through sleep so each start begins clamped at full current
  always_ff @(posedge clock) begin
    if (dev_rst || !ctrl_ff.run) begin
      loop_init_ff <= 1'b1;
    end else if (err_fast) begin
      loop_init_ff <= 1'b0;
    end
  end

  assign pump_up = pump_up_ff;
  assign pump_down = pump_dn_ff;
  assign loop_init_flag = loop_init_ff;

  // ------------------------------------------------------------
  // Diagnostic output
  // ------------------------------------------------------------
  logic diag_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      diag_ff <= 1'b0;
    end else begin
      case (swap2(ctrl_ff.diag_raw))
        DIAG_REV_A: diag_ff <= rev_a_ff;
        DIAG_THERM: diag_ff <= sy.therm;
        DIAG_SYNC: diag_ff <= ref_ff;
        default: diag_ff <= zero_cross_toggle_ff;
      endcase
    end
  end

  assign diag_out = diag_ff;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_brake_on;
    brake_latch_ff && !dev_rst;
  endsequence

  property p_hold_deselected;
    (!sel_rise && !dev_rst) |=> ctrl_ff == $past(ctrl_ff);
  endproperty
  a_hold_deselected: assert property (p_hold_deselected)
    else $error("control word changed without a latch");

  property p_latch;
    (sel_rise && !dev_rst) |=> ctrl_ff == $past(shift_word);
  endproperty
  a_latch: assert property (p_latch)
    else $error("shift word not latched on select rise");

  property p_clear;
    dev_rst |=> (ctrl_ff == CTL_RESET) && !run_mode;
  endproperty
  a_clear: assert property (p_clear)
    else $error("reset did not clear control word");

  property p_brake_drive;
    s_brake_on |=> drive_ff.hs == 3'h0 && drive_ff.ls == 3'h7;
  endproperty
  a_brake_drive: assert property (p_brake_drive)
    else $error("brake pattern wrong");

  property p_brake_hold;
    s_brake_on ##1 !dev_rst |-> brake_latch_ff;
  endproperty
  a_brake_hold: assert property (p_brake_hold)
    else $error("brake released without reset");

  property p_one_hot_drive;
    (ctrl_ff.run && !brake_latch_ff) |=>
      $onehot(drive_ff.hs) && $onehot(drive_ff.ls) && (drive_ff.hs & drive_ff.ls) == 3'h0;
  endproperty
  a_one_hot_drive: assert property (p_one_hot_drive)
    else $error("drive pattern not one source one sink");

  property p_wd_advance;
    (wd_fail && !dev_rst) |=> seq_ff != $past(seq_ff);
  endproperty
  a_wd_advance: assert property (p_wd_advance)
    else $error("watchdog did not advance sequencer");

  property p_step_only;
    (ctrl_ff.step && !rise.st_osc && !dev_rst) |=> seq_ff == $past(seq_ff);
  endproperty
  a_step_only: assert property (p_step_only)
    else $error("sequencer moved without oscillator in step mode");

  property p_ref_start;
    (rev_a_rise && ref_total != '0 && !dev_rst) |=> ref_ff ##1 ref_ff;
  endproperty
  a_ref_start: assert property (p_ref_start)
    else $error("reference pulse not started");

  property p_init_drop;
    (err_fast && ctrl_ff.run && !dev_rst) |=> !loop_init_ff;
  endproperty
  a_init_drop: assert property (p_init_drop)
    else $error("loop init flag not released");

  property p_zc_toggle;
    (zc_valid && !dev_rst) |=> zero_cross_toggle_ff != $past(zero_cross_toggle_ff);
  endproperty
  a_zc_toggle: assert property (p_zc_toggle)
    else $error("zero-cross toggle missed");

  property p_pole_keep;
    (sel_rise && swap2(shift_word.pole_raw) == POLE_RSVD && !dev_rst)
      |=> pole_code_ff == $past(pole_code_ff);
  endproperty
  a_pole_keep: assert property (p_pole_keep)
    else $error("reserved pole code changed pole count");

endmodule

`default_nettype wire

//--- rtl/bcs_pkg.sv
/*
 Shared types and constants for the motor commutation and speed control logic.
 Assumes a single system clock of 40 MHz and a serial link clocked by the host.
*/
package bcs_pkg;

  // ------------------------------------------------------------
  // Serial control word
  // ------------------------------------------------------------
  localparam int CTL_W = 24;
  localparam int REF_W = 18;
  localparam int REF_SHIFT = 4;

  // Raw field bit [1] holds the higher word bit (D4, D21, D23)
  typedef struct packed {
    logic [1:0] diag_raw;
    logic [1:0] pole_raw;
    logic sector;
    logic [13:0] ref_n;
    logic [1:0] ilim_raw;
    logic brake;
    logic step;
    logic run;
  } bcs_ctl_type;

  localparam logic [CTL_W-1:0] CTL_RESET = 24'h00_0000;

  // ------------------------------------------------------------
  // Field codes, written as {lower bit, higher bit}
  // ------------------------------------------------------------
  localparam logic [1:0] POLE_8 = 2'h0;
  localparam logic [1:0] POLE_RSVD = 2'h1;
  localparam logic [1:0] POLE_16 = 2'h2;
  localparam logic [1:0] POLE_12 = 2'h3;
  localparam logic [1:0] DIAG_REV_A = 2'h0;
  localparam logic [1:0] DIAG_THERM = 2'h1;
  localparam logic [1:0] DIAG_SYNC = 2'h2;
  localparam logic [1:0] DIAG_ZC = 2'h3;

  // Zero-crossing toggle cycles per revolution: three per pole pair
  localparam int ZCT_W = 5;
  localparam logic [ZCT_W-1:0] ZCT_CYC_8P = 5'h0c;
  localparam logic [ZCT_W-1:0] ZCT_CYC_12P = 5'h12;
  localparam logic [ZCT_W-1:0] ZCT_CYC_16P = 5'h18;

  // ------------------------------------------------------------
  // Pins from the analog side and the host
  // ------------------------------------------------------------
  typedef struct packed {
    logic reset_n;
    logic sel_n;
    logic brake_n;
    logic sector;
    logic osc;
    logic bemf;
    logic st_osc;
    logic cd_done;
    logic blank_end;
    logic wd_timeout;
    logic therm;
  } bcs_pin_type;

  localparam int PIN_W = 11;
  localparam logic [PIN_W-1:0] PIN_INIT = 11'h700;

  // Phase drivers, bit 0 = phase A
  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } bcs_drive_type;

  localparam logic [5:0] DRIVE_OFF = 6'h00;
  localparam logic [5:0] DRIVE_BRAKE = 6'h07;

  // Sequencer states, Gray coded around the ring
  typedef enum logic [2:0] {
    SEQ_S1 = 3'h0,
    SEQ_S2 = 3'h1,
    SEQ_S3 = 3'h3,
    SEQ_S4 = 3'h7,
    SEQ_S5 = 3'h6,
    SEQ_S6 = 3'h4
  } bcs_seq_type;

endpackage

//--- rtl/bcs_sync.sv
/*
 Two-flop synchroniser for a bundle of asynchronous levels.
 Assumes each bit is an independent level; no word coherence is promised.
*/
`timescale 1ns/10ps
`default_nettype none

module bcs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

`default_nettype wire

//--- verification/bcs_host_model.sv
/*
 Host model: writes the 24-bit serial control word on a 12 ns link clock.
 Assumes the caller leaves at least four system clocks between words.
*/
`timescale 1ns/10ps
`default_nettype none

module bcs_host_model (
  // Serial port
  output logic serial_clk,
  output logic port_sel_n,
  output logic serial_din
);
  // ----------------------------------------
  // Frames
  // ----------------------------------------
  // Clock stands low outside frames, so select may fall safely
  initial begin
    serial_clk = 1'b0;
    port_sel_n = 1'b1;
    serial_din = 1'b0;
  end

  // Bit 23 first, bit 0 last; data moves only while the clock is low
  task automatic send_word(input logic [23:0] w);
    #3.3 port_sel_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serial_din = w[i];
      #6 serial_clk = 1'b1;
      #6 serial_clk = 1'b0;
    end
    #6 port_sel_n = 1'b1;
    serial_din = ~serial_din; // No stale value once released
  endtask

  // Select pulse with no clocks: the word already shifted is latched again
  task automatic strobe;
    #3.3 port_sel_n = 1'b0;
    #75 port_sel_n = 1'b1;
  endtask

  // Clock and data activity with select high
  task automatic noise(input int n);
    repeat (n) begin
      serial_din = ~serial_din;
      #6 serial_clk = 1'b1;
      #6 serial_clk = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

//--- verification/test_bcs_ctrl_top.sv
/*
 Self-checking bench for the motor control core.
 Assumes the host model owns the serial pins and the bench all other pins.
*/
`timescale 1ns/10ps
`default_nettype none

module test_bcs_ctrl_top;
  import bcs_pkg::*;

  // ----------------------------------------
  // Signals, clocks, instances
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic serial_clk, port_sel_n, serial_din;
  logic reset_n = 1'b1, brake_n = 1'b1, sector_in = 1'b0, ref_osc_clock = 1'b0;
  logic st_osc_evt = 1'b0, cd_done_evt = 1'b0, blank_end_evt = 1'b0, wd_timeout_evt = 1'b0;
  logic therm_flag = 1'b0, bemf_cmp = 1'b0;
  bcs_drive_type drive;
  logic [1:0] ilim_code;
  logic run_mode, loop_init_flag, pump_up, pump_down, diag_out;
  int fail_count = 0;
  int comparisons = 0;
  int p;
  int n;
  // Drive {hs, ls} of the six states in ring order
  localparam logic [5:0] SEQ_TBL [6] = '{6'h0a, 6'h22, 6'h21, 6'h11, 6'h14, 6'h0c};

  always #12.5 clock = ~clock;
  always #50 ref_osc_clock = ~ref_osc_clock; // 10 MHz reference

  bcs_host_model bcs_host_model_inst (.serial_clk(serial_clk), .port_sel_n(port_sel_n),
    .serial_din(serial_din));

  // Comparator moves only under zc, so watchdog scenarios see bad polarity
  bcs_ctrl_top bcs_ctrl_top_inst (.clock(clock), .rst(rst), .serial_clk(serial_clk),
    .port_sel_n(port_sel_n), .serial_din(serial_din), .reset_n(reset_n), .brake_n(brake_n),
    .sector_in(sector_in), .ref_osc_clock(ref_osc_clock), .bemf_cmp(bemf_cmp),
    .st_osc_evt(st_osc_evt), .cd_done_evt(cd_done_evt), .blank_end_evt(blank_end_evt),
    .wd_timeout_evt(wd_timeout_evt), .therm_flag(therm_flag), .drive(drive),
    .ilim_code(ilim_code), .run_mode(run_mode), .loop_init_flag(loop_init_flag),
    .pump_up(pump_up), .pump_down(pump_down), .diag_out(diag_out));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #2;
  endtask

  task automatic chk(input logic [5:0] got, input logic [5:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Codes given {lower bit, higher bit}; bsr = {brake, step, run}; 8 poles
  function automatic logic [23:0] mk(input logic [1:0] dg, input logic sec,
      input logic [13:0] rn, input logic [1:0] il, input logic [2:0] bsr);
    return {dg[0], dg[1], 2'h0, sec, rn, il[0], il[1], bsr};
  endfunction

  // Word lands three edges after select rises; margin for outputs
  task automatic wr(input logic [23:0] w);
    bcs_host_model_inst.send_word(w);
    tick(7);
  endtask

  // Event pulse held three clocks, then time for step and drive
  task automatic ev(input int k);
    {wd_timeout_evt, blank_end_evt, cd_done_evt, st_osc_evt} = 4'h1 << k;
    tick(3);
    {wd_timeout_evt, blank_end_evt, cd_done_evt, st_osc_evt} = 4'h0;
    tick(5);
  endtask

  // Flips the comparator k times, five clocks apart, so outputs settle
  task automatic zc(input int k);
    repeat (k) begin
      bemf_cmp = ~bemf_cmp;
      tick(5);
    end
  endtask

  function automatic int pos(input logic [5:0] d);
    for (int i = 0; i < 6; i++) begin
      if (SEQ_TBL[i] === d) return i;
    end
    return 0;
  endfunction

  // Bounded wait for the reference pulse to end on the sync output
  task automatic wait_ref_end;
    while (n < 200 && diag_out !== 1'b0) begin
      tick(1);
      n++;
    end
    if (n >= 200) begin
      fail_count++;
      $display("ERROR %0t reference pulse never ended", $time);
      results();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_word;
    chk(drive, DRIVE_OFF, "reset drive");
    chk({ilim_code, run_mode, loop_init_flag, pump_up, pump_down}, 6'h04, "reset");
    for (int c = 0; c < 4; c++) begin
      wr(mk(DIAG_REV_A, 1'b0, 14'h3fff, c[1:0], 3'h1));
      chk({3'h0, ilim_code, run_mode}, {3'h0, c[1:0], 1'b1}, "limit");
    end
    bcs_host_model_inst.noise(30);
    bcs_host_model_inst.strobe();
    tick(7);
    chk({3'h0, ilim_code, run_mode}, 6'h07, "deselected");
    wr(mk(DIAG_REV_A, 1'b0, 14'h3fff, 2'h1, 3'h0));
    chk({3'h0, ilim_code, run_mode}, 6'h02, "sleep");
  endtask

  task automatic t_seq;
    wr(mk(DIAG_REV_A, 1'b0, 14'h3fff, 2'h0, 3'h3));
    p = pos(drive);
    chk(drive, SEQ_TBL[p], "start state");
    ev(1);
    chk(drive, SEQ_TBL[p], "step hold");
    for (int i = 0; i < 6; i++) begin
      ev(0);
      p = (p + 1) % 6;
      chk(drive, SEQ_TBL[p], "step");
    end
    wr(mk(DIAG_REV_A, 1'b0, 14'h3fff, 2'h0, 3'h1));
    ev(1);
    p = (p + 1) % 6;
    chk(drive, SEQ_TBL[p], "commutate");
    ev(2);
    ev(3);
    p = (p + 1) % 6;
    chk(drive, SEQ_TBL[p], "watchdog");
    // Crossings after blanking; rev_a toggles per turn of rising toggles
    wr(mk(DIAG_ZC, 1'b0, 14'h3fff, 2'h0, 3'h1));
    ev(2);
    zc(1);
    chk({5'h0, diag_out}, 6'h01, "zero cross");
    zc(21);
    wr(mk(DIAG_REV_A, 1'b0, 14'h3fff, 2'h0, 3'h1));
    chk({5'h0, diag_out}, 6'h00, "8 poles early");
    zc(2);
    chk({5'h0, diag_out}, 6'h01, "8 poles rev_a");
    wr(mk(DIAG_REV_A, 1'b0, 14'h3fff, 2'h0, 3'h1) | 24'h10_0000);
    zc(46);
    chk({5'h0, diag_out}, 6'h01, "16 poles early");
    zc(2);
    chk({5'h0, diag_out}, 6'h00, "16 poles rev_a");
    wr(mk(DIAG_REV_A, 1'b0, 14'h3fff, 2'h0, 3'h1) | 24'h30_0000);
    zc(34);
    chk({5'h0, diag_out}, 6'h00, "12 poles early");
    zc(2);
    chk({5'h0, diag_out}, 6'h01, "12 poles rev_a");
    wr(mk(DIAG_REV_A, 1'b0, 14'h3fff, 2'h0, 3'h1) | 24'h20_0000);
    zc(34);
    chk({5'h0, diag_out}, 6'h01, "reserved early");
    zc(2);
    chk({5'h0, diag_out}, 6'h00, "reserved keeps 12");
  endtask

  task automatic t_speed;
    wr(mk(DIAG_THERM, 1'b0, 14'h3fff, 2'h0, 3'h1));
    therm_flag = 1'b1;
    tick(6);
    chk({5'h0, diag_out}, 6'h01, "thermal");
    chk({5'h0, loop_init_flag}, 6'h01, "init flag");
    // Sector mode and count 16 in one write, sync still low
    wr(mk(DIAG_REV_A, 1'b1, 14'h3ffe, 2'h0, 3'h1));
    sector_in = 1'b1;
    tick(8);
    chk({5'h0, diag_out}, 6'h01, "sector rev_a");
    wr(mk(DIAG_SYNC, 1'b1, 14'h3ffe, 2'h0, 3'h1));
    n = 0;
    wait_ref_end();
    chk({5'h0, pump_up}, 6'h01, "pump up");
    sector_in = 1'b0;
    tick(6);
    chk({4'h0, pump_up, pump_down}, 6'h00, "pumps idle");
    sector_in = 1'b1;
    tick(8);
    chk({5'h0, diag_out}, 6'h01, "sync");
    n = 8;
    wait_ref_end();
    chk({5'h0, n >= 62 && n <= 76}, 6'h01, "ref length");
    sector_in = 1'b0;
    tick(6);
    sector_in = 1'b1;
    tick(10);
    sector_in = 1'b0;
    tick(6);
    chk({4'h0, pump_down, loop_init_flag}, 6'h02, "fast error");
  endtask

  task automatic t_brake;
    wr(mk(DIAG_REV_A, 1'b0, 14'h3fff, 2'h3, 3'h5));
    chk(drive, DRIVE_BRAKE, "word brake");
    wr(mk(DIAG_REV_A, 1'b0, 14'h3fff, 2'h3, 3'h1));
    chk(drive, DRIVE_BRAKE, "brake kept");
    reset_n = 1'b0;
    tick(6);
    chk({3'h0, ilim_code, run_mode}, 6'h00, "pin reset");
    chk(drive, DRIVE_OFF, "pin reset drive");
    reset_n = 1'b1;
    tick(4);
    wr(mk(DIAG_REV_A, 1'b0, 14'h3fff, 2'h0, 3'h1));
    brake_n = 1'b0;
    tick(6);
    brake_n = 1'b1;
    tick(6);
    chk(drive, DRIVE_BRAKE, "pin brake kept");
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
    tick(4);
    chk(drive, DRIVE_OFF, "reset clears brake");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(8);
    rst = 1'b0;
    tick(4);
    t_word();
    t_seq();
    t_speed();
    t_brake();
    results();
  end
endmodule

`default_nettype wire
